// >>> bench/scp_spi_master.sv
// Model of the system controller that masters the serial control port.
// Assumes the bench clock clk; every pin changes just after its rising edge.
`timescale 1ns/100ps
module scp_spi_master (
   // Clock
   input  wire logic clk,
   // Serial pins
   output logic      sclk,
   output logic      cs_n,
   output logic      sdio_drv,
   input  wire logic miso,
   // High while the shared pin must stay undriven
   output logic      quiet
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdio_drv = 1'b0;
      quiet = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////
   // Change on fall, sample while high
   task automatic bit_x(input logic b, input logic rel, output logic r);
      @(posedge clk);
      sclk <= 1'b0;
      sdio_drv <= rel ? ~sdio_drv : b;
      tick(4);
      sclk <= 1'b1;
      tick(2);
      r = miso;
      tick(1);
   endtask

   task automatic frame(input logic [15:0] ins, input logic [7:0] wd[$], input int nbits,
                        input bit lsb, input bit uni, input bit stall,
                        output logic [7:0] rd[$]);
      logic [7:0] r;
      logic       b;
      int         k;
      rd = {};
      r = 8'h00;
      @(posedge clk);
      cs_n <= 1'b0;
      quiet <= 1'b1;
      tick(4);
      for (int i = 0; i < 16; i++) begin
         bit_x(ins[lsb ? i : 15 - i], 1'b0, b);
      end
      quiet <= ~ins[15] | uni;
      for (int i = 0; i < nbits; i++) begin
         if (stall && i > 0 && i % 8 == 0) begin
            @(posedge clk);
            sclk <= 1'b0;
            cs_n <= 1'b1;
            tick(8);
            cs_n <= 1'b0;
            tick(4);
         end
         k = lsb ? i % 8 : 7 - i % 8;
         bit_x((wd.size() > i / 8) ? wd[i / 8][k] : 1'b0, ins[15], b);
         r[k] = b;
         if (i % 8 == 7) rd.push_back(r);
      end
      @(posedge clk);
      sclk <= 1'b0;
      tick(4);
      cs_n <= 1'b1;
      quiet <= 1'b0;
      tick(10);
   endtask
endmodule

// >>> bench/spi_control_port_slave_test.sv
// Self-checking bench of the serial control port slave.
// Assumes the master model drives the pins; the bench resolves the shared line.
`timescale 1ns/100ps
module spi_control_port_slave_test;
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   wire logic  sclk, cs_n, m_sdio, quiet;
   wire logic  sdio_out, sdio_oe_n, sdo_out, sdo_oe_n;
   wire logic  port_busy, lsb_first, unidir_mode, update_pulse;
   wire logic  sdio_line, miso;
   bit         lsb_now = 1'b0;
   bit         use_sep = 1'b0;
   int         err_total = 0;
   int         n_compared = 0;
   int         hi_cnt = 0;
   logic [7:0] upd_cnt = 8'h00;
   logic [7:0] q[$];
   logic [7:0] none[$];

   always #25 clk = ~clk;

   assign sdio_line = sdio_oe_n ? m_sdio : sdio_out;
   assign miso = use_sep ? (sdo_oe_n ? ~sdo_out : sdo_out) : sdio_line;

   scp_spi_slave uut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
      .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sdo_out(sdo_out),
      .sdo_oe_n(sdo_oe_n), .port_busy(port_busy), .lsb_first(lsb_first),
      .unidir_mode(unidir_mode), .update_pulse(update_pulse));

   scp_spi_master mst (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdio_drv(m_sdio), .miso(miso),
      .quiet(quiet));

   ////////////////////////////////////////////////////////////////
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t byte %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d[$], input bit stall = 1'b0);
      logic [1:0] len;
      len = (d.size() > 3) ? 2'h3 : 2'(d.size() - 1);
      mst.frame({1'b0, len, a}, d, d.size() * 8, lsb_now, use_sep, stall, q);
   endtask

   task automatic rd(input logic [12:0] a, input logic [1:0] len, input logic [7:0] exp[$]);
      mst.frame({1'b1, len, a}, none, exp.size() * 8, lsb_now, use_sep, 1'b0, q);
      foreach (exp[i]) chk_byte(q[i], exp[i]);
   endtask

   task automatic finish_test();
      if (err_total == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      hi_cnt <= cs_n ? hi_cnt + 1 : 0;
      if (update_pulse === 1'b1) upd_cnt <= upd_cnt + 8'h01;
      if (hi_cnt > 5 && reset_n) chk_flag(sdio_oe_n & sdo_oe_n, 1'b1);
      // Shared pin idle outside read data
      if (quiet) chk_flag(sdio_oe_n, 1'b1);
   end

   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      finish_test();
   end

   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk_flag(unidir_mode | lsb_first | port_busy, 1'b0);
      wr(13'h0012, {8'h11, 8'h22, 8'h33});
      rd(13'h0012, 2'h2, {8'h11, 8'h22, 8'h33});
      rd(13'h0011, 2'h1, {8'h22, 8'h33});
      wr(13'h0020, {8'h44, 8'h55}, 1'b1);
      rd(13'h0020, 2'h1, {8'h44, 8'h55});
      mst.frame({1'b1, 2'h1, 13'h0020}, none, 16, 1'b0, 1'b0, 1'b1, q);
      chk_byte(q[0], 8'h44);
      chk_byte(q[1], 8'h55);
      mst.frame(16'h0021, {8'hab}, 4, 1'b0, 1'b0, 1'b0, q);
      chk_flag(port_busy, 1'b0);
      rd(13'h0021, 2'h0, {8'h00});
      mst.frame({1'b0, 2'h1, 13'h0030}, {8'h99, 8'h77}, 12, 1'b0, 1'b0, 1'b1, q);
      chk_flag(port_busy, 1'b0);
      rd(13'h0030, 2'h1, {8'h99, 8'h00});
      wr(13'h0001, {8'h66, 8'h18, 8'h00, 8'hff});
      rd(13'h0001, 2'h3, {8'h66, 8'h18, 8'h00});
      rd(13'h0231, 2'h0, {8'h00});
      chk_byte(upd_cnt, 8'h00);
      wr(13'h0004, {8'h01});
      rd(13'h0012, 2'h0, {8'h00});
      wr(13'h0232, {8'h01});
      chk_byte(upd_cnt, 8'h01);
      rd(13'h0012, 2'h2, {8'h11, 8'h22, 8'h33});
      rd(13'h0232, 2'h0, {8'h00});
      wr(13'h0000, {8'h5a});
      chk_flag(lsb_first, 1'b1);
      lsb_now = 1'b1;
      wr(13'h0004, {8'h00});
      wr(13'h0040, {8'h77, 8'h88});
      rd(13'h0040, 2'h1, {8'h77, 8'h88});
      wr(13'h0000, {8'h18});
      lsb_now = 1'b0;
      chk_flag(lsb_first, 1'b0);
      rd(13'h0041, 2'h0, {8'h88});
      wr(13'h0000, {8'h81});
      chk_flag(unidir_mode, 1'b1);
      use_sep = 1'b1;
      rd(13'h0012, 2'h2, {8'h11, 8'h22, 8'h33});
      wr(13'h0000, {8'h18});
      use_sep = 1'b0;
      chk_flag(unidir_mode, 1'b0);
      finish_test();
   end
endmodule

// >>> hdl/scp_pkg.sv
// Shared constants and types of the serial control port.
// Assumes a single 20 MHz system clock; SPI pins are sampled, not used as clocks.
package scp_pkg;

   // Register map
   localparam int         NUM_REGS    = 32'h0000_0233;
   localparam logic [12:0] REG_END    = 13'h0233;
   localparam logic [12:0] REG_CFG    = 13'h0000;
   localparam logic [12:0] REG_RDSEL  = 13'h0004;
   localparam logic [12:0] REG_UPDATE = 13'h0232;
   localparam logic [7:0]  CFG_RST    = 8'h18;
   localparam logic [7:0]  BYTE_RST   = 8'h00;

   // Field positions
   localparam int CFG_UNIDIR_HI = 7;
   localparam int CFG_UNIDIR_LO = 0;
   localparam int CFG_LSB_HI    = 6;
   localparam int CFG_LSB_LO    = 1;
   localparam int RDSEL_BIT     = 0;
   localparam int UPDATE_BIT    = 0;
   localparam int INS_RW        = 15;
   localparam int INS_LEN_HI    = 14;
   localparam int INS_LEN_LO    = 13;
   localparam int INS_ADDR_HI   = 12;

   // Bit counts
   localparam logic [3:0] INSTR_LAST = 4'hf;
   localparam logic [3:0] BYTE_LAST  = 4'h7;
   localparam logic [1:0] LEN_STREAM = 2'h3;

   // Port sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_INSTR,
      ST_DATA,
      ST_STALL,
      ST_DONE
   } scp_state_t;

endpackage

// >>> hdl/scp_reg_if.sv
// Link between the serial port sequencer and the register store.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface scp_reg_if;
   logic        wr_en;
   logic [12:0] addr;
   logic [7:0]  wr_data;
   logic [7:0]  rd_data;
   logic [7:0]  cfg;
   logic        upd_pulse;

   modport port (
      output wr_en,
      output addr,
      output wr_data,
      input  rd_data,
      input  cfg,
      input  upd_pulse
   );

   modport store (
      input  wr_en,
      input  addr,
      input  wr_data,
      output rd_data,
      output cfg,
      output upd_pulse
   );
endinterface

// >>> hdl/scp_reg_store.sv
// Buffer and active register arrays with the update transfer.
// Assumes one write per cycle from the sequencer on the same clock.
`timescale 1ns/100ps
module scp_reg_store (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Sequencer side
   scp_reg_if.store rg
);

   typedef struct packed {
      logic [scp_pkg::NUM_REGS-1:0][7:0] buffer;
      logic [scp_pkg::NUM_REGS-1:0][7:0] active;
      logic                              upd;
   } scp_store_st_t;

   scp_store_st_t r_ff;
   scp_store_st_t nxt_r;
   logic          in_range;
   logic [9:0]    idx;

   assign in_range = (rg.addr < scp_pkg::REG_END);
   assign idx      = rg.addr[9:0];

   ////////////////////////////////////////////////////////////////////////////
   // Write and update
   always_comb begin
      nxt_r     = r_ff;
      nxt_r.upd = 1'b0;
      if (rg.wr_en && in_range) begin
         if (rg.addr == scp_pkg::REG_UPDATE) begin
            if (rg.wr_data[scp_pkg::UPDATE_BIT]) begin
               nxt_r.active = r_ff.buffer;
               nxt_r.upd    = 1'b1;
            end
         end else begin
            nxt_r.buffer[idx] = rg.wr_data;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         r_ff        <= '0;
         r_ff.buffer[scp_pkg::REG_CFG[9:0]] <= scp_pkg::CFG_RST;
         r_ff.active[scp_pkg::REG_CFG[9:0]] <= scp_pkg::CFG_RST;
      end else begin
         r_ff <= nxt_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read side
   // Buffer or active readback
   assign rg.rd_data   = (!in_range || rg.addr == scp_pkg::REG_UPDATE) ? scp_pkg::BYTE_RST :
                         (r_ff.buffer[scp_pkg::REG_RDSEL[9:0]][scp_pkg::RDSEL_BIT] ?
                          r_ff.active[idx] : r_ff.buffer[idx]);
   assign rg.cfg       = r_ff.buffer[scp_pkg::REG_CFG[9:0]];
   assign rg.upd_pulse = r_ff.upd;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   update_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
      rg.wr_en && rg.addr == scp_pkg::REG_UPDATE && rg.wr_data[scp_pkg::UPDATE_BIT]
      |=> r_ff.upd && r_ff.active == $past(r_ff.buffer))
      else $error("update did not copy buffer to active");

   reserved_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      rg.wr_en && in_range && rg.addr != scp_pkg::REG_UPDATE
      |=> r_ff.buffer[$past(idx)] == $past(rg.wr_data))
      else $error("written byte not held in buffer");

endmodule

// >>> hdl/scp_spi_slave.sv
// SPI serial control port slave: sequencer, pin drivers and register store.
// Assumes sclk, cs_n and sdio_in are asynchronous pins, sampled by a 20 MHz clk.
`timescale 1ns/100ps
module scp_spi_slave (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // SPI pins
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic sdio_in,
   output wire logic sdio_out,
   output wire logic sdio_oe_n,
   output wire logic sdo_out,
   output wire logic sdo_oe_n,
   // Status
   output wire logic port_busy,
   output wire logic lsb_first,
   output wire logic unidir_mode,
   output wire logic update_pulse
);

   typedef struct packed {
      scp_pkg::scp_state_t state;
      logic                sclk_m;
      logic                sclk_s;
      logic                sclk_d;
      logic                cs_m;
      logic                cs_s;
      logic                cs_d;
      logic                sdi_m;
      logic                sdi_s;
      logic [3:0]          bit_cnt;
      logic                is_read;
      logic                stream;
      logic                resume_data;
      logic [1:0]          len_left;
      logic [12:0]         addr;
      logic [15:0]         rx_sr;
      logic [7:0]          tx_sr;
      logic                out_bit;
      logic                load_pend;
   } scp_port_st_t;

   scp_port_st_t r_ff;
   scp_port_st_t nxt_r;
   scp_reg_if    rg ();

   logic         rise;
   logic         fall;
   logic         cs_rise;
   logic         cs_fall;
   logic         lsb;
   logic         unidir;
   logic         drive;
   logic         last_byte;
   logic [15:0]  rx_next;
   logic [7:0]   byte_in;
   logic         wr_en;
   logic [7:0]   wr_data;

   // Next address for multibyte transfers
   function automatic logic [12:0] step_addr(input logic [12:0] a, input logic up);
      logic [12:0] res;
      res = a + 13'h0001;
      if (!up) begin
         res = (a == scp_pkg::REG_CFG) ? scp_pkg::REG_UPDATE : a - 13'h0001;
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register store
   scp_reg_store u_store (
      .clk     (clk),
      .reset_n (reset_n),
      .rg      (rg.store)
   );

   assign rg.wr_en   = wr_en;
   assign rg.addr    = r_ff.addr;
   assign rg.wr_data = wr_data;

   ////////////////////////////////////////////////////////////////////////////
   // Pin edges and mode decode
   // Edges from synchronised clock and select
   assign rise    = r_ff.sclk_s & ~r_ff.sclk_d;
   assign fall    = ~r_ff.sclk_s & r_ff.sclk_d;
   assign cs_rise = r_ff.cs_s & ~r_ff.cs_d;
   assign cs_fall = ~r_ff.cs_s & r_ff.cs_d;
   assign lsb     = rg.cfg[scp_pkg::CFG_LSB_HI] & rg.cfg[scp_pkg::CFG_LSB_LO];
   assign unidir  = rg.cfg[scp_pkg::CFG_UNIDIR_HI] & rg.cfg[scp_pkg::CFG_UNIDIR_LO];
   assign rx_next = lsb ? {r_ff.sdi_s, r_ff.rx_sr[15:1]} : {r_ff.rx_sr[14:0], r_ff.sdi_s};
   assign byte_in = lsb ? rx_next[15:8] : rx_next[7:0];
   assign last_byte = r_ff.stream ? (r_ff.addr == scp_pkg::REG_UPDATE)
                                  : (r_ff.len_left == 2'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      nxt_r        = r_ff;
      wr_en        = 1'b0;
      wr_data      = scp_pkg::BYTE_RST;
      nxt_r.sclk_m = sclk;
      nxt_r.sclk_s = r_ff.sclk_m;
      nxt_r.sclk_d = r_ff.sclk_s;
      nxt_r.cs_m   = cs_n;
      nxt_r.cs_s   = r_ff.cs_m;
      nxt_r.cs_d   = r_ff.cs_s;
      nxt_r.sdi_m  = sdio_in;
      nxt_r.sdi_s  = r_ff.sdi_m;
      if (r_ff.load_pend) begin
         nxt_r.tx_sr     = rg.rd_data;
         nxt_r.load_pend = 1'b0;
      end
      unique case (r_ff.state)
         scp_pkg::ST_IDLE: begin
            if (cs_fall) begin
               nxt_r.state   = scp_pkg::ST_INSTR;
               nxt_r.bit_cnt = 4'h0;
            end
         end
         scp_pkg::ST_INSTR: begin
            if (cs_rise) begin
               if (r_ff.bit_cnt[2:0] != 3'h0 || r_ff.bit_cnt == 4'h0) begin
                  nxt_r.state = scp_pkg::ST_IDLE;
               end else begin
                  nxt_r.state       = scp_pkg::ST_STALL;
                  nxt_r.resume_data = 1'b0;
               end
            end else if (rise) begin
               nxt_r.rx_sr   = rx_next;
               nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
               if (r_ff.bit_cnt == scp_pkg::INSTR_LAST) begin
                  nxt_r.is_read   = rx_next[scp_pkg::INS_RW];
                  nxt_r.len_left  = rx_next[scp_pkg::INS_LEN_HI:scp_pkg::INS_LEN_LO];
                  nxt_r.stream    = (rx_next[scp_pkg::INS_LEN_HI:scp_pkg::INS_LEN_LO]
                                     == scp_pkg::LEN_STREAM);
                  nxt_r.addr      = rx_next[scp_pkg::INS_ADDR_HI:0];
                  nxt_r.bit_cnt   = 4'h0;
                  nxt_r.state     = scp_pkg::ST_DATA;
                  nxt_r.load_pend = 1'b1;
               end
            end
         end
         scp_pkg::ST_DATA: begin
            if (cs_rise) begin
               if (r_ff.bit_cnt == 4'h0 && !r_ff.stream) begin
                  nxt_r.state       = scp_pkg::ST_STALL;
                  nxt_r.resume_data = 1'b1;
                  if (fall && r_ff.is_read) begin
                     nxt_r.out_bit = lsb ? r_ff.tx_sr[0] : r_ff.tx_sr[7];
                     nxt_r.tx_sr   = lsb ? {1'b0, r_ff.tx_sr[7:1]} : {r_ff.tx_sr[6:0], 1'b0};
                  end
               end else begin
                  nxt_r.state = scp_pkg::ST_IDLE;
               end
            end else if (rise) begin
               nxt_r.rx_sr   = rx_next;
               nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
               if (r_ff.bit_cnt == scp_pkg::BYTE_LAST) begin
                  wr_en         = ~r_ff.is_read;
                  wr_data       = byte_in;
                  nxt_r.bit_cnt = 4'h0;
                  if (last_byte) begin
                     nxt_r.state = scp_pkg::ST_DONE;
                  end else begin
                     nxt_r.addr      = step_addr(r_ff.addr, lsb);
                     nxt_r.len_left  = r_ff.len_left - 2'h1;
                     nxt_r.load_pend = 1'b1;
                  end
               end
            end else if (fall && r_ff.is_read) begin
               nxt_r.out_bit = lsb ? r_ff.tx_sr[0] : r_ff.tx_sr[7];
               nxt_r.tx_sr   = lsb ? {1'b0, r_ff.tx_sr[7:1]} : {r_ff.tx_sr[6:0], 1'b0};
            end
         end
         scp_pkg::ST_STALL: begin
            if (cs_fall) begin
               nxt_r.state = r_ff.resume_data ? scp_pkg::ST_DATA : scp_pkg::ST_INSTR;
            end
         end
         scp_pkg::ST_DONE: begin
            if (cs_rise) begin
               nxt_r.state = scp_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         r_ff        <= '0;
         r_ff.sclk_m <= 1'b0;
         r_ff.cs_m   <= 1'b1;
         r_ff.cs_s   <= 1'b1;
         r_ff.cs_d   <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers and status
   assign drive = ~r_ff.cs_s & r_ff.is_read &
                  (r_ff.state == scp_pkg::ST_DATA || r_ff.state == scp_pkg::ST_DONE);
   // Shared pin only in read data
   assign sdio_oe_n    = ~(drive & ~unidir);
   assign sdo_oe_n     = ~(~r_ff.cs_s & unidir);
   assign sdio_out     = r_ff.out_bit;
   assign sdo_out      = r_ff.out_bit;
   assign port_busy    = (r_ff.state != scp_pkg::ST_IDLE);
   assign lsb_first    = lsb;
   assign unidir_mode  = unidir;
   assign update_pulse = rg.upd_pulse;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   cs_high_float_a: assert property (r_ff.cs_s |-> sdio_oe_n && sdo_oe_n)
      else $error("data pin driven while deselected");

   bidir_no_sdo_a: assert property (!unidir |-> sdo_oe_n)
      else $error("separate output driven in bidirectional mode");

   unidir_input_a: assert property (unidir |-> sdio_oe_n)
      else $error("shared pin driven in unidirectional mode");

   instr_end_a: assert property (
      r_ff.state == scp_pkg::ST_INSTR && rise && !cs_rise &&
      r_ff.bit_cnt == scp_pkg::INSTR_LAST
      |=> r_ff.state == scp_pkg::ST_DATA && r_ff.bit_cnt == 4'h0 ##1 !r_ff.load_pend)
      else $error("instruction did not end after sixteen rises");

   instr_decode_a: assert property (
      r_ff.state == scp_pkg::ST_INSTR && rise && !cs_rise &&
      r_ff.bit_cnt == scp_pkg::INSTR_LAST
      |=> r_ff.is_read == $past(rx_next[15]) && r_ff.addr == $past(rx_next[12:0]))
      else $error("instruction fields decoded wrongly");

   nonbyte_reset_a: assert property (
      (r_ff.state == scp_pkg::ST_INSTR || r_ff.state == scp_pkg::ST_DATA) &&
      cs_rise && r_ff.bit_cnt[2:0] != 3'h0 |=> r_ff.state == scp_pkg::ST_IDLE)
      else $error("mid-byte select rise did not reset");

   byte_stall_a: assert property (
      r_ff.state == scp_pkg::ST_DATA && cs_rise && r_ff.bit_cnt == 4'h0 && !r_ff.stream
      |=> r_ff.state == scp_pkg::ST_STALL ##1 (r_ff.state == scp_pkg::ST_STALL || cs_fall ||
          $past(cs_fall)))
      else $error("byte-boundary rise did not stall");

   stream_stop_a: assert property (
      r_ff.state == scp_pkg::ST_DATA && rise && !cs_rise && r_ff.stream &&
      r_ff.bit_cnt == scp_pkg::BYTE_LAST && r_ff.addr == scp_pkg::REG_UPDATE
      |=> r_ff.state == scp_pkg::ST_DONE)
      else $error("streaming passed the update register");

   msb_step_a: assert property (
      r_ff.state == scp_pkg::ST_DATA && rise && !cs_rise && !lsb && !last_byte &&
      r_ff.bit_cnt == scp_pkg::BYTE_LAST && r_ff.addr != scp_pkg::REG_CFG
      |=> r_ff.addr == $past(r_ff.addr) - 13'h0001)
      else $error("address did not decrement in MSB-first order");

   out_on_fall_a: assert property ($changed(r_ff.out_bit) |-> $past(fall))
      else $error("read data changed away from a falling edge");

   shared_drive_a: assert property (!sdio_oe_n |-> r_ff.is_read &&
      (r_ff.state == scp_pkg::ST_DATA || r_ff.state == scp_pkg::ST_DONE))
      else $error("shared pin driven outside read data");

endmodule
